// ==== logic/xbd_decoder.sv ====
// Address decoder and enable logic for the 16-Mbyte unified address space.
// Assumes CPU request signals on clk; the boot strap pin is asynchronous.
// What this block does
// R1 - Decode twelve user flash blocks by address
// R2 - Software programs flash from outside flash
// R3 - Boot mode maps test block at zero
// R4 - Last two blocks also reachable as aliases
// R5 - Flash control window needs its enable
// R6 - Flash control: 16-bit, no delay, bytes allowed
// R7 - Low RAM needs global and own enable
// R8 - Disabled RAM ranges go to external bus
// R9 - High RAM needs global and own enable
// R10 - RAM access is zero wait, 50ns
// R11 - No stack, register bank, bit use of RAM
// R12 - First CAN needs global and bit 0
// R13 - Second CAN needs global and bit 1
// R14 - Peripherals word only, 100ns access
// R15 - CAN in use limits segment lines to four
// R16 - Clock window needs global and bit 4
// R17 - PWM window needs global and bit 6
// R18 - Serial ports need global and bits 7, 8
// R19 - I2C and misc need global, bits 9, 10
// R20 - Disabled peripheral owns no space, pins, interrupts
// R21 - After init, disabled peripherals lose their clock; the clock follows the own enable bit only, not the global enable
// R22 - Gated peripherals get no reset afterwards
`include "xbd_defines.svh"
module xbd_decoder
  import xbd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        boot_mode,
  input  wire logic [15:0] system_config_reg,
  input  wire logic [15:0] periph_enable_reg,
  input  wire logic        acc_req,
  input  wire logic [23:0] acc_addr,
  input  wire logic        acc_byte,
  input  wire logic        acc_stack,
  input  wire logic        acc_bit,
  input  wire logic        end_init_instruction,
  input  wire logic        periph_reset_req,
  input  wire logic        ctl_bank1,
  input  wire logic [3:0]  ctl_block,
  output logic             acc_ack,
  output logic             acc_err,
  output logic [3:0]       acc_target,
  output logic [3:0]       flash_block,
  output logic             ext_req,
  output logic             flash_pe_allow,
  output logic [3:0]       ctl_phys_block,
  output logic             seg_lines_8,
  output logic [6:0]       clk_en,
  output logic [6:0]       periph_present,
  output logic [6:0]       periph_rst
);
  localparam int XC = `XBD_XRAM_CYC;   // Cycles of a RAM or flash control access.
  localparam int PC = `XBD_INTERNAL_PERIPH_BUS_CYC;   // Cycles of a peripheral access.

  xbd_state_e  state;                  // Access sequencer state.
  logic [3:0]  cnt;                    // Cycles left in the running access.
  logic        boot_s1;                // Strap synchroniser, first stage.
  logic        boot_s2;                // Strap synchroniser, second stage.
  logic        boot_q;                 // Boot mode as used by the decoder.
  logic        init_done;              // End of initialization has executed.
  logic        global_internal_periph_bus_enable;     // Global internal bus enable.
  logic        flash_ctrl_enable;      // Flash control window enable.
  logic [6:0]  pen;                    // Gateable peripheral enable bits.
  logic [9:0]  hit;                    // Window hits, one per window except misc.
  logic [4:0]  fmap;                   // Flash hit and block index.
  xbd_target_e next_target;            // Target of the offered access.
  logic        next_err;               // Offered access is refused.
  logic [3:0]  next_cnt;               // Cycle count to load on take.
  logic        take;                   // Request taken this cycle.

  // Peripheral order: CAN1, CAN2, clock, PWM, async, sync, I2C.
  assign global_internal_periph_bus_enable = system_config_reg[`XBD_GLOBAL_BIT];
  assign flash_ctrl_enable  = periph_enable_reg[`XBD_EN_FLCTL];
  assign pen = {periph_enable_reg[`XBD_EN_I2C], periph_enable_reg[`XBD_EN_SSC],
                periph_enable_reg[`XBD_EN_ASC], periph_enable_reg[`XBD_EN_PWM],
                periph_enable_reg[`XBD_EN_RTC], periph_enable_reg[`XBD_EN_CAN2],
                periph_enable_reg[`XBD_EN_CAN1]};
  assign take = acc_req && (state == XBD_IDLE);

  // Flash control window is gated by its own bit only.
  xbd_window #(.BASE(`XBD_FLCTL_BASE), .MASK(`XBD_SEG_MASK)) u_flctl
  (
    .addr   (acc_addr),
    .enable (flash_ctrl_enable),        // see R5
    .hit    (hit[0])
  );
  // Low RAM needs the global and its own enable.
  xbd_window #(.BASE(`XBD_LOW_EXT_RAM_BASE), .MASK(`XBD_LOW_EXT_RAM_MASK)) u_low_ext_ram
  (
    .addr   (acc_addr),
    .enable (global_internal_periph_bus_enable && periph_enable_reg[`XBD_EN_LOW_EXT_RAM]), // see R7
    .hit    (hit[1])
  );
  // High RAM needs the global and its own enable.
  xbd_window #(.BASE(`XBD_HIGH_EXT_RAM_BASE), .MASK(`XBD_HIGH_EXT_RAM_MASK)) u_high_ext_ram
  (
    .addr   (acc_addr),
    .enable (global_internal_periph_bus_enable && periph_enable_reg[`XBD_EN_HIGH_EXT_RAM]), // see R9
    .hit    (hit[2])
  );
  // First CAN window.
  xbd_window #(.BASE(`XBD_CAN1_BASE), .MASK(`XBD_PER_MASK)) u_can1
  (
    .addr   (acc_addr),
    .enable (global_internal_periph_bus_enable && pen[0]),   // see R12
    .hit    (hit[3])
  );
  // Second CAN window.
  xbd_window #(.BASE(`XBD_CAN2_BASE), .MASK(`XBD_PER_MASK)) u_can2
  (
    .addr   (acc_addr),
    .enable (global_internal_periph_bus_enable && pen[1]),   // see R13
    .hit    (hit[4])
  );
  // Real-time clock window.
  xbd_window #(.BASE(`XBD_RTC_BASE), .MASK(`XBD_PER_MASK)) u_rtc
  (
    .addr   (acc_addr),
    .enable (global_internal_periph_bus_enable && pen[2]),   // see R16
    .hit    (hit[5])
  );
  // PWM window.
  xbd_window #(.BASE(`XBD_PWM_BASE), .MASK(`XBD_PER_MASK)) u_pwm
  (
    .addr   (acc_addr),
    .enable (global_internal_periph_bus_enable && pen[3]),   // see R17
    .hit    (hit[6])
  );
  // Asynchronous serial window.
  xbd_window #(.BASE(`XBD_ASC_BASE), .MASK(`XBD_PER_MASK)) u_asc
  (
    .addr   (acc_addr),
    .enable (global_internal_periph_bus_enable && pen[4]),   // see R18
    .hit    (hit[7])
  );
  // Synchronous serial window.
  xbd_window #(.BASE(`XBD_SSC_BASE), .MASK(`XBD_PER_MASK)) u_ssc
  (
    .addr   (acc_addr),
    .enable (global_internal_periph_bus_enable && pen[5]),   // see R18
    .hit    (hit[8])
  );
  // I2C window; the misc window is compared inline below.
  xbd_window #(.BASE(`XBD_I2C_BASE), .MASK(`XBD_PER_MASK)) u_i2c
  (
    .addr   (acc_addr),
    .enable (global_internal_periph_bus_enable && pen[6]),   // see R19
    .hit    (hit[9])
  );

  // Map an address to a user flash block; bit 4 flags a hit.
  // The gap between the small blocks and block 4 is not flash.
  function automatic logic [4:0] flash_map(input xbd_addr_t a);
    logic [3:0] seg;
    seg = a[19:16];
    flash_map = 5'h00;
    if (a < `XBD_FL_SMALL_TOP)
    begin
      flash_map = {3'h4, a[14:13]};
    end
    else if ((a >= `XBD_FL_B4_BASE) && (a < `XBD_FL_B5_BASE))
    begin
      flash_map = 5'h14;
    end
    else if ((a >= `XBD_FL_B5_BASE) && (a < `XBD_FL_TOP))
    begin
      flash_map = {1'b1, 4'(seg + 4'h3)};
    end
  endfunction

  assign fmap = flash_map(acc_addr);           // see R1

  // Priority decode of the offered access, with refusal and length.
  always_comb
  begin
    next_target = XBD_T_EXT;
    next_err    = 1'b0;
    next_cnt    = 4'(XC - 1);
    if (boot_q && (acc_addr < `XBD_TF_TOP))
    begin
      // Test block hides the bottom of block 0 in boot mode only.
      next_target = XBD_T_TFL;                // see R3
    end
    else if (fmap[4])
    begin
      next_target = XBD_T_FLASH;              // see R1
    end
    else if (hit[0])
    begin
      next_target = XBD_T_FLCTL;              // see R5, R6
    end
    else if (hit[1] || hit[2])
    begin
      next_target = hit[1] ? XBD_T_LOW_EXT_RAM : XBD_T_HIGH_EXT_RAM; // see R10
      // RAM behaves like external memory: no stack, banks or bits.
      next_err = acc_stack || acc_bit;        // see R11
    end
    else if ((hit[9:3] != 7'h00) || (global_internal_periph_bus_enable && 
             periph_enable_reg[`XBD_EN_MISC] &&
             ((acc_addr & `XBD_PER_MASK) == `XBD_MISC_BASE)))
    begin
      next_target = XBD_T_MISC;
      if (hit[3]) next_target = XBD_T_CAN1;
      if (hit[4]) next_target = XBD_T_CAN2;
      if (hit[5]) next_target = XBD_T_RTC;
      if (hit[6]) next_target = XBD_T_PWM;
      if (hit[7]) next_target = XBD_T_ASC;
      if (hit[8]) next_target = XBD_T_SSC;
      if (hit[9]) next_target = XBD_T_I2C;
      next_cnt = 4'(PC - 1);                  // see R14
      // Byte access to a word-only window is answered with an error.
      next_err = acc_byte;                    // see R14
    end
    // Anything unclaimed, including disabled RAM, goes external.
    if (next_err)
    begin
      next_cnt = `XBD_CNT_RST;
    end
  end

  // Strap synchroniser; the decoder reads only the second stage.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      boot_s1 <= 1'b0;
      boot_s2 <= 1'b0;
    end
    else
    begin
      boot_s1 <= boot_mode;
      boot_s2 <= boot_s1;
    end
  end

  // Boot mode follows the strap until initialization ends, then freezes.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      boot_q <= 1'b0;
    end
    else if (!init_done)
    begin
      boot_q <= boot_s2;
    end
  end

  // Access sequencer: holds a taken access for its fixed length.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= XBD_IDLE;
      cnt   <= `XBD_CNT_RST;
    end
    else
    begin
      unique case (state)
        XBD_IDLE:
        begin
          // External accesses are handed off and not held here.
          if (take && (next_target != XBD_T_EXT))
          begin
            state <= XBD_BUSY;
            cnt   <= next_cnt;                // see R10, R14
          end
        end
        XBD_BUSY:
        begin
          if (cnt == 4'h0)
          begin
            state <= XBD_IDLE;
          end
          else
          begin
            cnt <= cnt - 4'h1;
          end
        end
        default:
        begin
          state <= XBD_IDLE;
        end
      endcase
    end
  end

  assign acc_ack = (state == XBD_BUSY) && (cnt == 4'h0);

  // Latch target, error and flash block of the taken access.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      acc_target  <= XBD_T_NONE;
      acc_err     <= 1'b0;
      flash_block <= 4'h0;
      ext_req     <= 1'b0;
    end
    else
    begin
      ext_req <= take && (next_target == XBD_T_EXT);  // see R8
      if (take)
      begin
        acc_target  <= next_target;
        acc_err     <= next_err;
        flash_block <= fmap[3:0];
      end
    end
  end

  // Alias bank: driver block 0 and 1 of bank 1 are physical 10 and 11.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctl_phys_block <= 4'h0;
    end
    else
    begin
      ctl_phys_block <= ctl_bank1 ? (ctl_block[0] ? 4'hB : 4'hA) : ctl_block; // see R4
    end
  end

  // Program and erase are only possible while the window is open.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      flash_pe_allow <= 1'b0;
    end
    else
    begin
      flash_pe_allow <= flash_ctrl_enable;    // see R5
    end
  end

  // Ownership of space, pins and interrupts per peripheral.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      periph_present <= 7'h00;
      seg_lines_8    <= 1'b1;
    end
    else
    begin
      periph_present <= {7{global_internal_periph_bus_enable}} & pen;   // see R20
      // A CAN in use takes four of the segment address pins.
      seg_lines_8 <= !(global_internal_periph_bus_enable && (pen[0] || pen[1])); // see R15
    end
  end

  // End of initialization is sticky until the next system reset.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      init_done <= 1'b0;
    end
    else if (end_init_instruction)
    begin
      init_done <= 1'b1;
    end
  end

  // Clocks run freely during init; afterwards only those with their own enable bit set run, whatever the global enable.
  // RAMs and the misc block are never gated, so they are not listed.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      clk_en     <= 7'h7F;
      periph_rst <= 7'h00;
    end
    else
    begin
      clk_en     <= init_done ? pen : 7'h7F;  // see R21
      // A gated peripheral is shielded from later resets.
      periph_rst <= {7{periph_reset_req}} & clk_en; // see R22
    end
  end

  a_xram_time: assert property (@(posedge clk) disable iff (!rstn) // see R10
    take && hit[1] && !next_err && !fmap[4] |-> ##[XC:XC] acc_ack)
    else $error("RAM access length wrong");
  a_internal_periph_bus_time: assert property (@(posedge clk) disable iff (!rstn) // see R14
    take && hit[3] && !acc_byte && !fmap[4] |-> ##[PC:PC] acc_ack)
    else $error("Peripheral access length wrong");
  a_byte_refused: assert property (@(posedge clk) disable iff (!rstn) // see R14
    take && (hit[9:3] != 7'h00) && acc_byte |=> acc_err ##0 acc_ack)
    else $error("Byte access to peripheral not refused");
  a_stack_refused: assert property (@(posedge clk) disable iff (!rstn) // see R11
    take && (hit[1] || hit[2]) && (acc_stack || acc_bit) && !fmap[4] |=> acc_err && acc_ack)
    else $error("Stack use of RAM not refused");
  a_flctl_closed: assert property (@(posedge clk) disable iff (!rstn) // see R5
    take && !flash_ctrl_enable && ((acc_addr & `XBD_SEG_MASK) == `XBD_FLCTL_BASE)
    |=> ext_req && !flash_pe_allow)
    else $error("Closed flash control window answered");
  a_xram_fall: assert property (@(posedge clk) disable iff (!rstn) // see R8
    take && !global_internal_periph_bus_enable && ((acc_addr & `XBD_LOW_EXT_RAM_MASK) == `XBD_LOW_EXT_RAM_BASE)
    |=> ext_req && (acc_target == XBD_T_EXT))
    else $error("Disabled RAM not sent external");
  a_boot_tflash: assert property (@(posedge clk) disable iff (!rstn) // see R3
    take && (acc_addr < `XBD_TF_TOP) |=> (acc_target == XBD_T_TFL) == $past(boot_q))
    else $error("Test block mapping wrong");
  a_gate_init: assert property (@(posedge clk) disable iff (!rstn) // see R21
    init_done && !pen[2] |=> !clk_en[2])
    else $error("Disabled peripheral still clocked");
  a_gated_rst: assert property (@(posedge clk) disable iff (!rstn) // see R22
    !clk_en[2] |=> !periph_rst[2])
    else $error("Reset reached gated peripheral");
  a_can_seg: assert property (@(posedge clk) disable iff (!rstn) // see R15
    periph_present[1] |-> !seg_lines_8)
    else $error("Segment lines not limited");
endmodule

// ==== logic/xbd_defines.svh ====
// Address map, enable bit positions and access timing of the address decoder.
// Assumes a 24-bit byte address and the 125 MHz core clock.
`ifndef XBD_DEFINES_SVH
`define XBD_DEFINES_SVH
// Enable bit positions in the system and peripheral configuration words.
`define XBD_GLOBAL_BIT 2
`define XBD_EN_CAN1    0
`define XBD_EN_CAN2    1
`define XBD_EN_LOW_EXT_RAM   2
`define XBD_EN_HIGH_EXT_RAM   3
`define XBD_EN_RTC     4
`define XBD_EN_FLCTL   5
`define XBD_EN_PWM     6
`define XBD_EN_ASC     7
`define XBD_EN_SSC     8
`define XBD_EN_I2C     9
`define XBD_EN_MISC    10
// Window bases and masks.
`define XBD_FLCTL_BASE 24'h0E0000
`define XBD_SEG_MASK   24'hFF0000
`define XBD_LOW_EXT_RAM_BASE 24'h00E000
`define XBD_LOW_EXT_RAM_MASK 24'hFFF800
`define XBD_HIGH_EXT_RAM_BASE 24'h0F0000
`define XBD_HIGH_EXT_RAM_MASK 24'hFF8000
`define XBD_PER_MASK   24'hFFFF00
`define XBD_CAN1_BASE  24'h00EF00
`define XBD_CAN2_BASE  24'h00EE00
`define XBD_RTC_BASE   24'h00ED00
`define XBD_PWM_BASE   24'h00EC00
`define XBD_MISC_BASE  24'h00EB00
`define XBD_I2C_BASE   24'h00EA00
`define XBD_ASC_BASE   24'h00E900
`define XBD_SSC_BASE   24'h00E800
// User flash layout and the boot test block.
`define XBD_FL_SMALL_TOP 24'h008000
`define XBD_FL_B4_BASE   24'h018000
`define XBD_FL_B5_BASE   24'h020000
`define XBD_FL_TOP       24'h090000
`define XBD_TF_TOP       24'h001000
// Access times in ns and the derived cycle counts, rounded up.
`define XBD_CLK_MHZ  125
`define XBD_XRAM_NS  50
`define XBD_INTERNAL_PERIPH_BUS_NS  100
`define XBD_XRAM_CYC ((`XBD_XRAM_NS * `XBD_CLK_MHZ + 999) / 1000)
`define XBD_INTERNAL_PERIPH_BUS_CYC ((`XBD_INTERNAL_PERIPH_BUS_NS * `XBD_CLK_MHZ + 999) / 1000)
`define XBD_CNT_RST  4'h0
`endif

// ==== logic/xbd_pkg.sv ====
// Types shared by the address decoder files.
// Assumes nothing beyond the defines header.
package xbd_pkg;
  // Access sequencer states.
  typedef enum logic [1:0] {
    XBD_IDLE = 2'b00,
    XBD_BUSY = 2'b01
  } xbd_state_e;
  // Decoded access targets.
  typedef enum logic [3:0] {
    XBD_T_NONE  = 4'h0,
    XBD_T_FLASH = 4'h1,
    XBD_T_TFL   = 4'h2,
    XBD_T_FLCTL = 4'h3,
    XBD_T_LOW_EXT_RAM = 4'h4,
    XBD_T_HIGH_EXT_RAM = 4'h5,
    XBD_T_CAN1  = 4'h6,
    XBD_T_CAN2  = 4'h7,
    XBD_T_RTC   = 4'h8,
    XBD_T_PWM   = 4'h9,
    XBD_T_ASC   = 4'hA,
    XBD_T_SSC   = 4'hB,
    XBD_T_I2C   = 4'hC,
    XBD_T_MISC  = 4'hD,
    XBD_T_EXT   = 4'hE
  } xbd_target_e;
  typedef logic [23:0] xbd_addr_t;
endpackage

// ==== logic/xbd_window.sv ====
// One address window comparator of the decoder.
// Assumes a base aligned to its mask.
module xbd_window
  import xbd_pkg::*;
#(
  parameter xbd_addr_t BASE = 24'h000000,
  parameter xbd_addr_t MASK = 24'hFFFFFF
)
(
  input  wire logic [23:0] addr,
  input  wire logic        enable,
  output logic             hit
);
  // A disabled window never claims its range, so the access falls through.
  assign hit = enable && ((addr & MASK) == BASE);
endmodule

// ==== sim/tb.sv ====
// Self-checking testbench of the address decoder.
// Assumes the decoder files and the CPU model are compiled before this file.
`define CHK(g, e) check_val(32'(g), 32'(e))
module tb
  import xbd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // Access times in cycles of the 8 ns clock, rounded up.
  localparam int RAM_CYC = (50 * 125 + 999) / 1000;
  localparam int PER_CYC = (100 * 125 + 999) / 1000;

  // One access case; m holds byte, stack and bit use, NONE marks a refused access.
  typedef struct {
    logic [23:0] a;
    logic [2:0]  m;
    xbd_target_e tgt;
    int          cyc;
    logic [3:0]  blk;
  } xbd_case_s;

  logic        clk;
  logic        rstn;
  logic        boot_mode;
  logic [15:0] system_config_reg;
  logic [15:0] periph_enable_reg;
  logic        acc_req;
  logic [23:0] acc_addr;
  logic        acc_byte;
  logic        acc_stack;
  logic        acc_bit;
  logic        end_init_instruction;
  logic        periph_reset_req;
  logic        ctl_bank1;
  logic [3:0]  ctl_block;
  logic        acc_ack;
  logic        acc_err;
  logic [3:0]  acc_target;
  logic [3:0]  flash_block;
  logic        ext_req;
  logic        flash_pe_allow;
  logic [3:0]  ctl_phys_block;
  logic        seg_lines_8;
  logic [6:0]  clk_en;
  logic [6:0]  periph_present;
  logic [6:0]  periph_rst;
  int          fails;
  int          n_tests;

  // Window bases indexed by their enable bit position.
  logic [23:0] base [11] = '{24'h00EF00, 24'h00EE00, 24'h00E000, 24'h0F0000, 24'h00ED00,
    24'h0E0000, 24'h00EC00, 24'h00E900, 24'h00E800, 24'h00EA00, 24'h00EB00};

  // Every target but the test block with all enables set, including boundaries and refused kinds.
  xbd_case_s tab [25] = '{
    '{24'h000000, 3'h0, XBD_T_FLASH, RAM_CYC, 4'h0}, '{24'h007FFE, 3'h0, XBD_T_FLASH, RAM_CYC, 4'h3},
    '{24'h018000, 3'h0, XBD_T_FLASH, RAM_CYC, 4'h4}, '{24'h020000, 3'h0, XBD_T_FLASH, RAM_CYC, 4'h5},
    '{24'h070000, 3'h0, XBD_T_FLASH, RAM_CYC, 4'hA}, '{24'h08FFFE, 3'h0, XBD_T_FLASH, RAM_CYC, 4'hB},
    '{24'h008000, 3'h0, XBD_T_EXT, 1, 4'h0}, '{24'h090000, 3'h0, XBD_T_EXT, 1, 4'h0},
    '{24'h0E0011, 3'h4, XBD_T_FLCTL, RAM_CYC, 4'h0}, '{24'h00E001, 3'h4, XBD_T_LOW_EXT_RAM, RAM_CYC, 4'h0},
    '{24'h00E7FE, 3'h0, XBD_T_LOW_EXT_RAM, RAM_CYC, 4'h0}, '{24'h0F0000, 3'h0, XBD_T_HIGH_EXT_RAM, RAM_CYC, 4'h0},
    '{24'h0F7FFF, 3'h4, XBD_T_HIGH_EXT_RAM, RAM_CYC, 4'h0}, '{24'h0F8000, 3'h0, XBD_T_EXT, 1, 4'h0},
    '{24'h00EF00, 3'h0, XBD_T_CAN1, PER_CYC, 4'h0}, '{24'h00EE00, 3'h0, XBD_T_CAN2, PER_CYC, 4'h0},
    '{24'h00ED00, 3'h0, XBD_T_RTC, PER_CYC, 4'h0}, '{24'h00EC00, 3'h0, XBD_T_PWM, PER_CYC, 4'h0},
    '{24'h00E900, 3'h0, XBD_T_ASC, PER_CYC, 4'h0}, '{24'h00E8FE, 3'h0, XBD_T_SSC, PER_CYC, 4'h0},
    '{24'h00EA00, 3'h0, XBD_T_I2C, PER_CYC, 4'h0}, '{24'h00EBFE, 3'h0, XBD_T_MISC, PER_CYC, 4'h0},
    '{24'h00EF01, 3'h4, XBD_T_NONE, 1, 4'h0}, '{24'h00E000, 3'h2, XBD_T_NONE, 1, 4'h0},
    '{24'h0F0000, 3'h1, XBD_T_NONE, 1, 4'h0}};

  xbd_decoder i_dut (
    .clk                  (clk),
    .rstn                 (rstn),
    .boot_mode            (boot_mode),
    .system_config_reg    (system_config_reg),
    .periph_enable_reg    (periph_enable_reg),
    .acc_req              (acc_req),
    .acc_addr             (acc_addr),
    .acc_byte             (acc_byte),
    .acc_stack            (acc_stack),
    .acc_bit              (acc_bit),
    .end_init_instruction (end_init_instruction),
    .periph_reset_req     (periph_reset_req),
    .ctl_bank1            (ctl_bank1),
    .ctl_block            (ctl_block),
    .acc_ack              (acc_ack),
    .acc_err              (acc_err),
    .acc_target           (acc_target),
    .flash_block          (flash_block),
    .ext_req              (ext_req),
    .flash_pe_allow       (flash_pe_allow),
    .ctl_phys_block       (ctl_phys_block),
    .seg_lines_8          (seg_lines_8),
    .clk_en               (clk_en),
    .periph_present       (periph_present),
    .periph_rst           (periph_rst)
  );

  xbd_cpu_model i_cpu (
    .clk       (clk),
    .acc_ack   (acc_ack),
    .ext_req   (ext_req),
    .acc_req   (acc_req),
    .acc_addr  (acc_addr),
    .acc_byte  (acc_byte),
    .acc_stack (acc_stack),
    .acc_bit   (acc_bit)
  );

  // The clock toggles every half period of 4 ns.
  always #4 clk = ~clk;

  // Compares with case equality so that an unknown never passes.
  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Runs one access and checks answer time, answer kind, error flag, target and block.
  task automatic acc(input xbd_case_s c);
    int n;
    i_cpu.access(c.a, c.m[2], c.m[1], c.m[0], n);
    if (n < 0)
    begin
      fails++;
      conclude();
    end
    `CHK(n, c.cyc);
    `CHK({acc_ack, ext_req}, (c.tgt == XBD_T_EXT) ? 2'h1 : 2'h2);
    if (c.tgt != XBD_T_EXT)
      `CHK(acc_err, c.tgt == XBD_T_NONE);
    if (c.tgt != XBD_T_NONE)
      `CHK(acc_target, c.tgt);
    if (c.tgt == XBD_T_FLASH)
      `CHK(flash_block, c.blk);
  endtask

  // Applies a configuration, lets it settle and checks the static outputs.
  task automatic cfg(input logic glob, input logic [15:0] en);
    logic [6:0] p;
    #1;
    system_config_reg = {13'h0000, glob, 2'h0};
    periph_enable_reg = en;
    repeat (2) @(posedge clk);
    p = {en[9], en[8], en[7], en[6], en[4], en[1], en[0]} & {7{glob}};
    `CHK(periph_present, p);
    `CHK(seg_lines_8, !(p[0] | p[1]));
    `CHK(flash_pe_allow, en[5]);
  endtask

  // Main sequence: reset, then each group of checks in turn.
  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    boot_mode = 1'b0;
    system_config_reg = 16'h0000;
    periph_enable_reg = 16'h0000;
    end_init_instruction = 1'b0;
    periph_reset_req = 1'b0;
    ctl_bank1 = 1'b0;
    ctl_block = 4'h0;
    fails = 0;
    n_tests = 0;
    repeat (5) @(posedge clk);
    `CHK({acc_ack, ext_req, seg_lines_8, clk_en, periph_present}, 17'h07F80);
    #1;
    rstn = 1'b1;
    repeat (3) @(posedge clk);
    $display("test reset finished");
    // Full map with every enable set.
    cfg(1'b1, 16'h07FF);
    foreach (tab[i])
      acc(tab[i]);
    $display("test decode finished");
    // Each window loses its space when only its own enable is cleared.
    for (int i = 0; i < 11; i++)
    begin
      cfg(1'b1, 16'h07FF & ~(16'h0001 << i));
      acc('{base[i], 3'h0, XBD_T_EXT, 1, 4'h0});
    end
    // Without the global enable everything but the flash window goes outside.
    cfg(1'b0, 16'h07FF);
    for (int i = 0; i < 11; i++)
      if (i != 5)
        acc('{base[i], 3'h0, XBD_T_EXT, 1, 4'h0});
    acc('{24'h0E0000, 3'h0, XBD_T_FLCTL, RAM_CYC, 4'h0});
    $display("test enables finished");
    // Boot mode shows the test block at zero only below 4 Kbytes.
    cfg(1'b1, 16'h07FF);
    #1;
    boot_mode = 1'b1;
    repeat (4) @(posedge clk);
    acc('{24'h000000, 3'h0, XBD_T_TFL, RAM_CYC, 4'h0});
    acc('{24'h000FFE, 3'h0, XBD_T_TFL, RAM_CYC, 4'h0});
    acc('{24'h001000, 3'h0, XBD_T_FLASH, RAM_CYC, 4'h0});
    #1;
    boot_mode = 1'b0;
    repeat (4) @(posedge clk);
    acc('{24'h000000, 3'h0, XBD_T_FLASH, RAM_CYC, 4'h0});
    $display("test boot finished");
    // Second-bank block names reach the last two physical blocks.
    for (int i = 0; i < 3; i++)
    begin
      #1;
      ctl_bank1 = (i < 2);
      ctl_block = (i == 2) ? 4'h7 : 4'(i);
      repeat (2) @(posedge clk);
      `CHK(ctl_phys_block, (i == 2) ? 4'h7 : 4'hA + 4'(i));
    end
    $display("test alias finished");
    // Clock gating and reset blocking after the end of initialization.
    cfg(1'b1, 16'h0025);
    #1;
    periph_reset_req = 1'b1;
    repeat (2) @(posedge clk);
    `CHK(clk_en, 7'h7F);
    `CHK(periph_rst, 7'h7F);
    #1;
    end_init_instruction = 1'b1;
    @(posedge clk);
    #1;
    end_init_instruction = 1'b0;
    repeat (3) @(posedge clk);
    `CHK(clk_en, 7'h01);
    `CHK(periph_rst, 7'h01);
    $display("test gating finished");
    conclude();
  end
endmodule

// ==== sim/xbd_cpu_model.sv ====
// CPU-side model that issues accesses on the decoder's request port.
// Assumes the decoder answers on clk with acc_ack or ext_req and takes requests while idle.
module xbd_cpu_model
(
  input  wire logic        clk,
  input  wire logic        acc_ack,
  input  wire logic        ext_req,
  output logic             acc_req,
  output logic [23:0]      acc_addr,
  output logic             acc_byte,
  output logic             acc_stack,
  output logic             acc_bit
);
  timeunit 1ns;
  timeprecision 100ps;

  // The port is quiet until the first access.
  initial
  begin
    acc_req   = 1'b0;
    acc_addr  = 24'hFFFFFF;
    acc_byte  = 1'b0;
    acc_stack = 1'b0;
    acc_bit   = 1'b0;
  end

  // One access: the request is pulsed for the take edge, then the answer is awaited.
  // Only read cycles are issued, so flash is never written while code runs from it.
  // The result n counts edges after the take edge, or stays -1 when no answer came.
  task automatic access(input logic [23:0] a, input logic b, input logic s, input logic t,
                        output int n);
    n = -1;
    #1;
    acc_req   = 1'b1;
    acc_addr  = a;
    acc_byte  = b;
    acc_stack = s;
    acc_bit   = t;
    @(posedge clk);
    #1;
    // Released lines show the inverse, so a stale address can never be decoded by luck.
    acc_req  = 1'b0;
    acc_addr = ~a;
    for (int i = 1; i <= 40 && n < 0; i++)
    begin
      @(posedge clk);
      if (acc_ack === 1'b1 || ext_req === 1'b1)
        n = i;
    end
  endtask
endmodule
